// File: logic/aas_consts.svh
// register offsets, field positions, reset values and timing counts of the autoscan converter control
`ifndef AAS_CONSTS_SVH
`define AAS_CONSTS_SVH

`define AAS_OFS_PIN_LEVEL     8'hC7
`define AAS_OFS_CHAN_SELECT   8'hE7
`define AAS_OFS_CONTROL       8'hD7
`define AAS_OFS_RESULT_LOW0   8'hB0
`define AAS_OFS_RESULT_HIGH   8'hB8

`define AAS_BIT_PRESCALE_HI   7
`define AAS_BIT_PRESCALE_LO   6
`define AAS_BIT_RESERVED      5
`define AAS_BIT_DONE          4
`define AAS_BIT_START         3
`define AAS_BIT_CONTINUOUS    2
`define AAS_BIT_RISE_EN       1
`define AAS_BIT_FALL_EN       0

`define AAS_RST_CONTROL       8'h00
`define AAS_RST_CHAN_SELECT   8'h00

`define AAS_MC_CLOCKS         12
`define AAS_SAMPLE_STEPS      2
`define AAS_STORE_STEP        12
`define AAS_RESULT_BITS       10
`define AAS_CHANNELS          8

`endif

// File: logic/aas_pkg.sv
// types shared by the autoscan converter control and its bench
package aas_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } aas_sfr_req_type;

    typedef struct packed {
        logic [2:0] mux_sel;
        logic       sample;
        logic [9:0] dac_code;
        logic       busy;
    } aas_analog_type;

    typedef enum logic [1:0] {
        AAS_IDLE,
        AAS_CONVERT,
        AAS_GAP
    } aas_state_type;

endpackage : aas_pkg

// File: logic/aas_autoscan.sv
// autoscan sequencing, registers and result storage of the 8-channel 10-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "aas_consts.svh"

// Notes on behaviour
// - prescaler codes divide by 2,4,6,8
// - one conversion takes 6m+1 machine cycles
// - done flag set after every scan loop
// - set done flag requests interrupt when enabled
// - done flag cleared only by software, reset
// - start bit set starts the selected scan
// - continuous bit repeats loops, else one
// - continuous mode keeps start bit set
// - one-time mode clears start bit at end
// - start commands ignored while start bit set
// - software clearing start bit aborts conversion
// - enabled rising edge starts and captures
// - enabled falling edge starts and captures
// - convert set mask bits, lowest first
// - empty mask never starts a conversion
// - new mask takes effect next loop
// - per-channel result, low byte bits 7..0
// - low read latches top bits into high
// - results read-only, untouched by reset
// - pin level port shows live pin levels
// - reset clears control and select mask
// - idle aborts, clears start, halts clock
// - idle leaves done flag unchanged
module aas_autoscan
    import aas_pkg::*;
#(
    parameter int MC_CLOCKS = `AAS_MC_CLOCKS
) (
    input  wire logic            clock,
    input  wire logic            srst,
    input  wire aas_sfr_req_type sfr_req,
    output logic [7:0]           sfr_rdata,
    input  wire logic            idle_req,
    input  wire logic            adc_int_enable,
    output logic                 adc_irq,
    input  wire logic            external_start_pin,
    output logic                 capture_pulse,
    input  wire logic            comp_above,
    input  wire logic [7:0]      analog_channel_input,
    output aas_analog_type       analog_ctl
);

    localparam int MCW = $clog2(MC_CLOCKS + 1);

    // control fields
    logic [1:0]    prescale_reg;
    logic          continuous_scan_reg;
    logic          rise_start_enable_reg;
    logic          fall_start_enable_reg;
    logic          scan_done_flag_reg;
    logic          start_status_reg;
    logic          start_pending_reg;
    logic [7:0]    channel_select_mask_reg;
    logic [7:0]    loop_mask_reg;

    // sequencer
    aas_state_type state_reg;
    logic [MCW-1:0] mc_cnt_reg;
    logic          mc_tick;
    logic [1:0]    sub_reg;
    logic [3:0]    step_reg;
    logic [3:0]    gap_reg;
    logic [2:0]    chan_reg;
    logic [9:0]    sar_reg;
    logic          sample_reg;

    // results and read side
    logic [9:0]    result_mem [0:`AAS_CHANNELS-1];
    logic [1:0]    high_latch_reg;
    logic [7:0]    rdata_reg;

    // synchronisers
    logic [7:0]    pin_meta_reg;
    logic [7:0]    pin_level_reg;
    logic          ext_meta_reg;
    logic          ext_sync_reg;
    logic          ext_prev_reg;
    logic          comp_meta_reg;
    logic          comp_sync_reg;
    logic          ext_start_reg;
    logic          capture_reg;
    logic          irq_reg;

    logic          wr_ctl;
    logic          wr_mask;
    logic          rise_edge;
    logic          fall_edge;
    logic          ext_edge_hit;
    logic          sw_start;
    logic          sw_stop;
    logic          start_req;
    logic          abort;
    logic [1:0]    half_m;
    logic          step_end;
    logic          last_chan;
    logic [2:0]    next_chan;
    logic [2:0]    first_chan;
    logic          store_now;
    logic          loop_end;
    logic          begin_loop;
    logic [3:0]    gap_len;
    logic [3:0]    after_chan;
    logic [3:0]    lowest_chan;

    // lowest set bit of a mask at or above a given position
    function automatic logic [3:0] next_set(input logic [7:0] mask, input logic [3:0] from);
        logic [3:0] found;
        found = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (mask[i] && (4'(i) >= from)) begin
                found = 4'(i);
            end
        end
        return found;
    endfunction : next_set

    assign wr_ctl  = sfr_req.wr && (sfr_req.addr == `AAS_OFS_CONTROL);
    assign wr_mask = sfr_req.wr && (sfr_req.addr == `AAS_OFS_CHAN_SELECT);

    // two flops before any logic looks at outside levels
    always_ff @(posedge clock) begin
        pin_meta_reg  <= analog_channel_input;
        pin_level_reg <= pin_meta_reg;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ext_meta_reg  <= 1'b0;
            ext_sync_reg  <= 1'b0;
            ext_prev_reg  <= 1'b0;
            comp_meta_reg <= 1'b0;
            comp_sync_reg <= 1'b0;
        end else begin
            ext_meta_reg  <= external_start_pin;
            ext_sync_reg  <= ext_meta_reg;
            ext_prev_reg  <= ext_sync_reg;
            comp_meta_reg <= comp_above;
            comp_sync_reg <= comp_meta_reg;
        end
    end

    assign rise_edge    = ext_sync_reg && !ext_prev_reg && rise_start_enable_reg;
    assign fall_edge    = !ext_sync_reg && ext_prev_reg && fall_start_enable_reg;
    assign ext_edge_hit = rise_edge || fall_edge;

    // capture and the start request leave on the same edge
    always_ff @(posedge clock) begin
        if (srst) begin
            capture_reg   <= 1'b0;
            ext_start_reg <= 1'b0;
        end else begin
            capture_reg   <= ext_edge_hit;
            ext_start_reg <= ext_edge_hit && !idle_req;
        end
    end

    assign sw_start  = wr_ctl && sfr_req.wdata[`AAS_BIT_START];
    assign sw_stop   = wr_ctl && !sfr_req.wdata[`AAS_BIT_START];
    assign abort     = sw_stop || idle_req;
    // a start waits while the done flag is set; an empty mask never starts
    assign start_req = !start_status_reg && !abort && (channel_select_mask_reg != 8'h00)
                       && !scan_done_flag_reg && (sw_start || ext_start_reg || start_pending_reg);
    assign begin_loop = start_req;

    // control fields; reserved bit is not stored so it always reads zero
    always_ff @(posedge clock) begin
        if (srst) begin
            prescale_reg          <= 2'(`AAS_RST_CONTROL >> `AAS_BIT_PRESCALE_LO);
            continuous_scan_reg   <= 1'b0;
            rise_start_enable_reg <= 1'b0;
            fall_start_enable_reg <= 1'b0;
        end else if (wr_ctl) begin
            prescale_reg          <= sfr_req.wdata[`AAS_BIT_PRESCALE_HI:`AAS_BIT_PRESCALE_LO];
            continuous_scan_reg   <= sfr_req.wdata[`AAS_BIT_CONTINUOUS];
            rise_start_enable_reg <= sfr_req.wdata[`AAS_BIT_RISE_EN];
            fall_start_enable_reg <= sfr_req.wdata[`AAS_BIT_FALL_EN];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            channel_select_mask_reg <= `AAS_RST_CHAN_SELECT;
        end else if (wr_mask) begin
            channel_select_mask_reg <= sfr_req.wdata;
        end
    end

    // a set wins over a clear in the same cycle; writing one does nothing
    always_ff @(posedge clock) begin
        if (srst) begin
            scan_done_flag_reg <= 1'b0;
        end else if (loop_end) begin
            scan_done_flag_reg <= 1'b1;
        end else if (wr_ctl && !sfr_req.wdata[`AAS_BIT_DONE]) begin
            scan_done_flag_reg <= 1'b0;
        end
    end

    // a start written while the done flag is set is kept until it clears
    always_ff @(posedge clock) begin
        if (srst || abort || start_req) begin
            start_pending_reg <= 1'b0;
        end else if (sw_start && !start_status_reg && scan_done_flag_reg) begin
            start_pending_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || abort) begin
            start_status_reg <= 1'b0;
        end else if (start_req) begin
            start_status_reg <= 1'b1;
        end else if (loop_end && !(continuous_scan_reg && (channel_select_mask_reg != 8'h00))) begin
            start_status_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= scan_done_flag_reg && adc_int_enable;
        end
    end

    // machine cycle divider; stops while idle
    always_ff @(posedge clock) begin
        if (srst || idle_req || state_reg == AAS_IDLE) begin
            mc_cnt_reg <= '0;
        end else if (mc_cnt_reg == MCW'(MC_CLOCKS - 1)) begin
            mc_cnt_reg <= '0;
        end else begin
            mc_cnt_reg <= mc_cnt_reg + 1'b1;
        end
    end
    assign mc_tick = (state_reg != AAS_IDLE) && !idle_req && (mc_cnt_reg == MCW'(MC_CLOCKS - 1));

    // one bit time is m/2 machine cycles
    assign half_m     = prescale_reg;
    assign step_end   = mc_tick && (sub_reg == half_m);
    assign store_now  = mc_tick && (state_reg == AAS_CONVERT) && (step_reg == 4'(`AAS_STORE_STEP));
    assign after_chan  = next_set(loop_mask_reg, {1'b0, chan_reg} + 4'h1);
    assign lowest_chan = next_set(channel_select_mask_reg, 4'h0);
    assign next_chan   = (after_chan == 4'h8) ? chan_reg : after_chan[2:0];
    assign last_chan   = (after_chan == 4'h8);
    assign first_chan  = lowest_chan[2:0];
    assign loop_end   = store_now && last_chan && !abort;
    // gap after storage makes a channel slot 7m machine cycles
    assign gap_len    = {1'b0, half_m, 1'b1};

    always_ff @(posedge clock) begin
        if (srst || abort) begin
            state_reg  <= AAS_IDLE;
            sample_reg <= 1'b0;
            sub_reg    <= 2'h0;
            step_reg   <= 4'h0;
            gap_reg    <= 4'h0;
        end else begin
            unique case (state_reg)
                AAS_IDLE: begin
                    if (begin_loop) begin
                        state_reg     <= AAS_CONVERT;
                        loop_mask_reg <= channel_select_mask_reg;
                        chan_reg      <= first_chan;
                        sample_reg    <= 1'b1;
                        sub_reg       <= 2'h0;
                        step_reg      <= 4'h0;
                    end
                end
                AAS_CONVERT: begin
                    if (store_now) begin
                        result_mem[chan_reg] <= sar_reg;
                        state_reg <= AAS_GAP;
                        gap_reg   <= gap_len;
                    end else if (step_end) begin
                        sub_reg  <= 2'h0;
                        step_reg <= step_reg + 4'h1;
                        if (step_reg == 4'(`AAS_SAMPLE_STEPS - 1)) begin
                            sample_reg <= 1'b0;
                            sar_reg    <= 10'h200;
                        end else if (step_reg >= 4'(`AAS_SAMPLE_STEPS)) begin
                            sar_reg <= sar_step(sar_reg, step_reg, comp_sync_reg);
                        end
                    end else if (mc_tick) begin
                        sub_reg <= sub_reg + 2'h1;
                    end
                end
                AAS_GAP: begin
                    if (mc_tick) begin
                        if (gap_reg != 4'h1) begin
                            gap_reg <= gap_reg - 4'h1;
                        end else if (!start_status_reg) begin
                            state_reg <= AAS_IDLE;
                        end else if (!last_chan) begin
                            state_reg  <= AAS_CONVERT;
                            chan_reg   <= next_chan;
                            sample_reg <= 1'b1;
                            step_reg   <= 4'h0;
                            sub_reg    <= 2'h0;
                        end else if (channel_select_mask_reg != 8'h00) begin
                            state_reg     <= AAS_CONVERT;
                            loop_mask_reg <= channel_select_mask_reg;
                            chan_reg      <= first_chan;
                            sample_reg    <= 1'b1;
                            step_reg      <= 4'h0;
                            sub_reg       <= 2'h0;
                        end else begin
                            state_reg <= AAS_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // keep the tried bit when the input is above the ladder, then try the next one
    function automatic logic [9:0] sar_step(input logic [9:0] code, input logic [3:0] step, input logic keep);
        logic [9:0] res;
        logic [3:0] bitn;
        bitn = 4'(`AAS_STORE_STEP - 1) - step;
        res  = code;
        if (!keep) begin
            res[bitn] = 1'b0;
        end
        if (bitn != 4'h0) begin
            res[bitn - 4'h1] = 1'b1;
        end
        return res;
    endfunction : sar_step

    // read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else if (sfr_req.rd) begin
            if (sfr_req.addr == `AAS_OFS_CONTROL) begin
                rdata_reg <= {prescale_reg, 1'b0, scan_done_flag_reg, start_status_reg,
                              continuous_scan_reg, rise_start_enable_reg, fall_start_enable_reg};
            end else if (sfr_req.addr == `AAS_OFS_CHAN_SELECT) begin
                rdata_reg <= channel_select_mask_reg;
            end else if (sfr_req.addr == `AAS_OFS_PIN_LEVEL) begin
                rdata_reg <= pin_level_reg;
            end else if (sfr_req.addr[7:3] == `AAS_OFS_RESULT_LOW0 >> 3) begin
                rdata_reg <= result_mem[sfr_req.addr[2:0]][7:0];
            end else if (sfr_req.addr == `AAS_OFS_RESULT_HIGH) begin
                rdata_reg <= {6'h00, high_latch_reg};
            end else begin
                rdata_reg <= 8'h00;
            end
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // result storage and the high latch carry no reset on purpose
    always_ff @(posedge clock) begin
        if (sfr_req.rd && (sfr_req.addr[7:3] == `AAS_OFS_RESULT_LOW0 >> 3)) begin
            high_latch_reg <= result_mem[sfr_req.addr[2:0]][9:8];
        end
    end

    assign sfr_rdata           = rdata_reg;
    assign adc_irq             = irq_reg;
    assign capture_pulse       = capture_reg;
    assign analog_ctl.mux_sel  = chan_reg;
    assign analog_ctl.sample   = sample_reg;
    assign analog_ctl.dac_code = sar_reg;
    assign analog_ctl.busy     = start_status_reg;

endmodule : aas_autoscan
`default_nettype wire

// File: tb/aas_analog_model.sv
// comparator and input multiplexer model facing the autoscan control
`timescale 1ns/10ps
`default_nettype none
module aas_analog_model
    import aas_pkg::*;
(
    input  wire logic           clock,
    input  wire aas_analog_type analog_ctl,
    input  wire logic [9:0]     level [8],
    output logic                comp_above
);
    // input held at code+0.5 lsb, so the decision never sits on a tie
    // outside a scan the output toggles so a stale decision is never reused
    always_ff @(posedge clock) begin
        if (analog_ctl.busy)
            comp_above <= (analog_ctl.dac_code <= level[analog_ctl.mux_sel]);
        else
            comp_above <= ~comp_above;
    end
endmodule : aas_analog_model
`default_nettype wire

// File: tb/aas_autoscan_checker.sv
// port assertions for the autoscan converter control
`timescale 1ns/10ps
`default_nettype none
module aas_autoscan_checker
    import aas_pkg::*;
#(
    parameter int MC_CLOCKS = 12
) (
    input wire logic            clock,
    input wire logic            srst,
    input wire aas_sfr_req_type sfr_req,
    input wire logic [7:0]      sfr_rdata,
    input wire logic            idle_req,
    input wire logic            adc_int_enable,
    input wire logic            adc_irq,
    input wire logic            external_start_pin,
    input wire logic            capture_pulse,
    input wire logic            comp_above,
    input wire logic [7:0]      analog_channel_input,
    input wire aas_analog_type  analog_ctl
);
    logic [5:0] pin_hist;
    logic       ctl_wr;

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    always_ff @(posedge clock) pin_hist <= {pin_hist[4:0], external_start_pin};
    assign ctl_wr = sfr_req.wr && sfr_req.addr == 8'hD7;

    irq_masked_a: assert property (!adc_int_enable |=> !adc_irq)
        else $error("irq raised while disabled");
    high_upper_a: assert property (sfr_req.rd && sfr_req.addr == 8'hB8 |=> sfr_rdata[7:2] == 6'h00)
        else $error("high byte upper bits not zero");
    reserved_read_a: assert property (sfr_req.rd && sfr_req.addr == 8'hD7 |=> !sfr_rdata[5])
        else $error("reserved control bit reads one");
    idle_stop_a: assert property (idle_req |=> !analog_ctl.busy && !analog_ctl.sample)
        else $error("converter active in idle");
    sw_abort_a: assert property (ctl_wr && !sfr_req.wdata[3] && analog_ctl.busy |=> !analog_ctl.busy)
        else $error("software clear did not abort");
    // a pending start may fire one cycle after the clearing write
    start_cause_a: assert property ($rose(analog_ctl.busy) |->
        $past(ctl_wr) || $past(ctl_wr, 2) || $past(capture_pulse))
        else $error("scan started without a start command");
    edge_capture_a: assert property (capture_pulse |-> (pin_hist[4:1] ^ pin_hist[3:0]) != 4'h0)
        else $error("capture without a start pin edge");
    pin_port_a: assert property (sfr_req.rd && sfr_req.addr == 8'hC7 && $stable(analog_channel_input)
        && $past(analog_channel_input, 1) == $past(analog_channel_input, 3)
        |=> sfr_rdata == $past(analog_channel_input))
        else $error("pin port read wrong level");
    sample_busy_a: assert property ($rose(analog_ctl.sample) |-> analog_ctl.busy)
        else $error("sampling outside a scan");
    reset_clear_a: assert property (disable iff (1'b0) srst |=>
        !analog_ctl.busy && !capture_pulse && !adc_irq && sfr_rdata == 8'h00)
        else $error("outputs not cleared by reset");
endmodule : aas_autoscan_checker

bind aas_autoscan aas_autoscan_checker #(.MC_CLOCKS(MC_CLOCKS)) u_checker (
    .clock(clock), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .idle_req(idle_req),
    .adc_int_enable(adc_int_enable), .adc_irq(adc_irq), .external_start_pin(external_start_pin),
    .capture_pulse(capture_pulse), .comp_above(comp_above), .analog_channel_input(analog_channel_input),
    .analog_ctl(analog_ctl));
`default_nettype wire

// File: tb/aas_autoscan_tb.sv
// self-checking bench for the autoscan converter control
`timescale 1ns/10ps
`default_nettype none
module aas_autoscan_tb;
    import aas_pkg::*;
    // 4 clocks a machine cycle keeps the comparator sync inside one bit time
    localparam int MC = 4;
    logic            clock = 1'b0;
    logic            srst = 1'b1;
    aas_sfr_req_type sfr_req = '0;
    logic [7:0]      sfr_rdata;
    logic            idle_req = 1'b0;
    logic            adc_int_enable = 1'b0;
    logic            adc_irq;
    logic            external_start_pin = 1'b0;
    logic            capture_pulse;
    logic            comp_above;
    logic [7:0]      pins = 8'h00;
    aas_analog_type  analog_ctl;
    logic [9:0]      level [8];
    logic            smp_q = 1'b0;
    logic [2:0]      order [$];
    int              mismatches = 0;
    int              checks = 0;
    int              seed = 69851;
    int              busy_len;

    aas_autoscan #(.MC_CLOCKS(MC)) DUT (
        .clock(clock), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .idle_req(idle_req),
        .adc_int_enable(adc_int_enable), .adc_irq(adc_irq), .external_start_pin(external_start_pin),
        .capture_pulse(capture_pulse), .comp_above(comp_above), .analog_channel_input(pins),
        .analog_ctl(analog_ctl));
    aas_analog_model u_model (.clock(clock), .analog_ctl(analog_ctl), .level(level), .comp_above(comp_above));

    initial forever #50 clock = ~clock;

    // channel seen at each start of sampling, in scan order
    always @(posedge clock) begin
        if (analog_ctl.sample && !smp_q)
            order.push_back(analog_ctl.mux_sel);
        smp_q <= analog_ctl.sample;
    end

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        sfr_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        sfr_req.wr <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        sfr_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        sfr_req.rd <= 1'b0;
        #1 v = sfr_rdata;
        @(posedge clock);
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk({8'h00, v}, {8'h00, exp});
    endtask : rdchk

    task automatic res_chk(input int i);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(8'(8'hB0 + i), lo);
        rd(8'hB8, hi);
        chk({6'h00, hi[1:0], lo}, {6'h00, level[i]});
    endtask : res_chk

    task automatic wait_idle(input int limit);
        busy_len = 0;
        while (analog_ctl.busy !== 1'b0 && busy_len < limit) begin
            @(posedge clock);
            busy_len++;
        end
        chk(16'(busy_len < limit), 16'h0001);
    endtask : wait_idle

    // every slot but the last is 7m machine cycles; the last ends at its store
    function automatic int conv_len(input int n, input int m);
        return ((n - 1) * 7 * m + 6 * m + 1) * MC;
    endfunction : conv_len

    initial begin
        #3000000;
        mismatches++;
        final_report();
    end

    initial begin
        logic [7:0] mask;
        logic       cap;
        int         m;
        int         n;
        int         lim;
        pins <= 8'($random(seed));
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rdchk(8'hD7, 8'h00);
        rdchk(8'hE7, 8'h00);
        rdchk(8'h00, 8'h00);
        rdchk(8'hC7, pins);
        wr(8'hD7, 8'h10);
        rdchk(8'hD7, 8'h00);
        wr(8'hD7, 8'h08);
        repeat (4) @(posedge clock);
        chk(16'(analog_ctl.busy), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            mask = (k == 0) ? 8'h80 : (k == 3) ? 8'hFF : 8'($random(seed)) | 8'h01;
            m = 2 * k + 2;
            for (int i = 0; i < 8; i++)
                level[i] = 10'($random(seed));
            level[0] = (k == 1) ? 10'h000 : (k == 2) ? 10'h3FF : level[0];
            adc_int_enable <= k[0];
            order.delete();
            wr(8'hE7, mask);
            wr(8'hD7, {k[1:0], 6'h08});
            wait_idle(20000);
            lim = conv_len($countones(mask), m);
            chk(16'(busy_len + m * MC + 4 >= lim && busy_len <= lim + 2 * m * MC), 16'h0001);
            rdchk(8'hD7, {k[1:0], 6'h10});
            chk(16'(adc_irq), 16'(k[0]));
            n = 0;
            for (int i = 0; i < 8; i++)
                if (mask[i]) begin
                    chk(16'(order[n]), 16'(i));
                    res_chk(i);
                    n++;
                end
            chk(16'(order.size()), 16'(n));
            wr(8'hD7, 8'h00);
            rdchk(8'hD7, 8'h00);
        end
        order.delete();
        wr(8'hE7, 8'h03);
        wr(8'hD7, 8'h0C);
        repeat (20) @(posedge clock);
        wr(8'hE7, 8'h04);
        for (int t = 0; t < 3000 && order.size() < 4; t++)
            @(posedge clock);
        chk({4'h0, order[0], order[1], order[2], order[3]}, 16'h0052);
        chk(16'(analog_ctl.busy), 16'h0001);
        rdchk(8'hD7, 8'h1C);
        wr(8'hD7, 8'h04);
        chk(16'(analog_ctl.busy), 16'h0000);
        wr(8'hE7, 8'h01);
        for (int e = 0; e < 2; e++)
            for (int j = 0; j < 2; j++) begin
                wr(8'hD7, e ? 8'h01 : 8'h02);
                cap = 1'b0;
                external_start_pin <= ~external_start_pin;
                repeat (6) begin
                    @(posedge clock);
                    cap = cap | capture_pulse;
                end
                chk(16'({cap, analog_ctl.busy}), ((j == 0) == (e == 0)) ? 16'h0003 : 16'h0000);
                wait_idle(2000);
            end
        idle_req <= 1'b1;
        repeat (2) @(posedge clock);
        idle_req <= 1'b0;
        rdchk(8'hD7, 8'h11);
        wr(8'hD7, 8'h00);
        wr(8'hE7, 8'hFF);
        wr(8'hD7, 8'h08);
        repeat (30) @(posedge clock);
        idle_req <= 1'b1;
        repeat (2) @(posedge clock);
        chk(16'({analog_ctl.busy, analog_ctl.sample}), 16'h0000);
        idle_req <= 1'b0;
        rdchk(8'hD7, 8'h00);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rdchk(8'hE7, 8'h00);
        res_chk(7);
        final_report();
    end
endmodule : aas_autoscan_tb
`default_nettype wire
